// ===== rtl/bsi_scan_top.v
`timescale 1ns/1ps
`include "bsi_consts.vh"
// Overview of operation
// - Three-bit instruction: shift stage plus latch
// - Shift-IR shifts instruction toward serial output
// - Update-IR falling edge latches instruction
// - SAMPLE selects boundary register, captures pins
// - SAMPLE lets Shift-DR preload boundary register
// - EXTEST drives outputs from boundary latches
// - EXTEST Capture-DR loads input pins
// - BYPASS uses one-bit bypass stage
// - CLAMP and HIGHZ also use bypass
// - IDCODE selects identification register
// - Capture-DR loads identification value
// - Test-Logic-Reset forces identification instruction
// - ID: bit0 one, maker, device, version
// - Identification: 32-bit shift plus latch
// - Boundary register: shift path plus latches
// - State changes only on rising clock edges
// - Power-up in Test-Logic-Reset with IDCODE
module bsi_scan_top #(
   parameter [10:0] MFR_CODE = 11'h2A5, // Arbitrary value
   parameter [15:0] DEV_CODE = 16'h1234, // Arbitrary value
   parameter [3:0]  VER_CODE = 4'h1     // Arbitrary value
) (
   input  wire                     clk_sys,
   input  wire                     rst,
   input  wire                     scan_clock,
   input  wire                     scan_mode_select,
   input  wire                     scan_serial_in,
   output reg                      scanSerialOutO,
   output reg                      scanSerialOutOeN,
   input  wire [`BSI_NUM_IN-1:0]   sysPinIn,
   input  wire [`BSI_NUM_OUT-1:0]  sysOut,
   input  wire                     sysOutEnN,
   output reg  [`BSI_NUM_OUT-1:0]  pinOut,
   output reg                      pinOutEnN,
   output reg  [`BSI_IR_W-1:0]     curInstr,
   output reg  [3:0]               tapStateIdx
);
   // TAP states, one-hot: reset, idle and data column
   localparam [15:0] S_TLR = 16'h0001;
   localparam [15:0] S_RTI = 16'h0002;
   localparam [15:0] S_SDR = 16'h0004;
   localparam [15:0] S_CDR = 16'h0008;
   localparam [15:0] S_SHD = 16'h0010;
   localparam [15:0] S_E1D = 16'h0020;
   localparam [15:0] S_PDR = 16'h0040;
   localparam [15:0] S_E2D = 16'h0080;
   localparam [15:0] S_UDR = 16'h0100;
   // Instruction column
   localparam [15:0] S_SIR = 16'h0200;
   localparam [15:0] S_CIR = 16'h0400;
   localparam [15:0] S_SHI = 16'h0800;
   localparam [15:0] S_E1I = 16'h1000;
   localparam [15:0] S_PIR = 16'h2000;
   localparam [15:0] S_E2I = 16'h4000;
   localparam [15:0] S_UIR = 16'h8000;

   localparam [`BSI_ID_W-1:0] ID_VALUE = {VER_CODE, DEV_CODE, MFR_CODE, 1'b1};

   // Synchronised pins and test-clock edges
   wire [2:0]             pinSync;
   wire [`BSI_NUM_IN-1:0] pinInSync;
   wire                   tck;
   wire                   tms;
   wire                   tdi;
   reg                    tckPrev_r;
   reg [15:0]             state_r;
   reg [15:0]             state_nxt;
   reg                    shiftOut_nxt;
   wire                   tckRise;
   wire                   tckFall;
   wire [`BSI_IR_W-1:0]   irShift;
   wire [`BSI_IR_W-1:0]   irPar;
   wire [`BSI_ID_W-1:0]   idShift;
   wire [`BSI_BSR_W-1:0]  bsrShift;
   wire [`BSI_BSR_W-1:0]  bsrPar;
   reg                    bypass_r;
   reg                    updIrPend_r;
   reg                    updDrPend_r;
   wire                   selBsr;
   wire                   selId;
   wire                   selBypass;
   wire [`BSI_BSR_W-1:0]  bsrCapture;

   // Encoded index of a one-hot state
   function [3:0] stIdx;
      input [15:0] s;
      integer i;
      begin
         stIdx = 4'h0;
         for (i = 0; i < 16; i = i + 1) begin
            if (s[i]) begin
               stIdx = i[3:0];
            end
         end
      end
   endfunction

   // Pin mode of an instruction: 0 system, 1 boundary latches, 2 floating
   function [1:0] pinMode;
      input [`BSI_IR_W-1:0] op;
      begin
         case (op)
            `BSI_OP_HIGHZ:  pinMode = 2'h2;
            `BSI_OP_EXTEST: pinMode = 2'h1;
            `BSI_OP_CLAMP:  pinMode = 2'h1;
            default:        pinMode = 2'h0;
         endcase
      end
   endfunction

   // Pins from the test controller are asynchronous
   bsi_sync #(.W(3)) uSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn ({scan_clock, scan_mode_select, scan_serial_in}),
      .syncOut (pinSync)
   );
   assign tck = pinSync[2];
   assign tms = pinSync[1];
   assign tdi = pinSync[0];

   // Digital input pins are asynchronous as well
   bsi_sync #(.W(`BSI_NUM_IN)) uPinSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn (sysPinIn),
      .syncOut (pinInSync)
   );

   // Edge detect on synchronised test clock
   always @(posedge clk_sys) begin
      if (rst) begin
         tckPrev_r <= 1'b0;
      end else begin
         tckPrev_r <= tck;
      end
   end
   assign tckRise = tck & ~tckPrev_r;
   assign tckFall = ~tck & tckPrev_r;

   // Next-state logic driven by mode select
   always @* begin
      case (state_r)
         S_TLR:   state_nxt = tms ? S_TLR : S_RTI;
         S_RTI:   state_nxt = tms ? S_SDR : S_RTI;
         S_SDR:   state_nxt = tms ? S_SIR : S_CDR;
         S_CDR:   state_nxt = tms ? S_E1D : S_SHD;
         S_SHD:   state_nxt = tms ? S_E1D : S_SHD;
         S_E1D:   state_nxt = tms ? S_UDR : S_PDR;
         S_PDR:   state_nxt = tms ? S_E2D : S_PDR;
         S_E2D:   state_nxt = tms ? S_UDR : S_SHD;
         S_UDR:   state_nxt = tms ? S_SDR : S_RTI;
         S_SIR:   state_nxt = tms ? S_TLR : S_CIR;
         S_CIR:   state_nxt = tms ? S_E1I : S_SHI;
         S_SHI:   state_nxt = tms ? S_E1I : S_SHI;
         S_E1I:   state_nxt = tms ? S_UIR : S_PIR;
         S_PIR:   state_nxt = tms ? S_E2I : S_PIR;
         S_E2I:   state_nxt = tms ? S_UIR : S_SHI;
         S_UIR:   state_nxt = tms ? S_SDR : S_RTI;
         default: state_nxt = S_TLR;
      endcase
   end

   // State register advances only on rising test-clock edges
   always @(posedge clk_sys) begin
      if (rst) begin
         state_r <= S_TLR;
      end else if (tckRise) begin
         state_r <= state_nxt;
      end
   end

   // Instruction decode
   assign selBsr    = (irPar == `BSI_OP_SAMPLE) | (irPar == `BSI_OP_EXTEST);
   assign selId     = (irPar == `BSI_OP_IDCODE);
   assign selBypass = ~selBsr & ~selId;

   // Update pulses latch on the falling edge inside Update states
   always @(posedge clk_sys) begin
      if (rst) begin
         updIrPend_r <= 1'b0;
         updDrPend_r <= 1'b0;
      end else if (tckRise) begin
         updIrPend_r <= (state_nxt == S_UIR);
         updDrPend_r <= (state_nxt == S_UDR);
      end else if (tckFall) begin
         updIrPend_r <= 1'b0;
         updDrPend_r <= 1'b0;
      end
   end

   // Instruction register
   bsi_shreg #(.W(`BSI_IR_W)) uIr (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .loadEn   (tckRise & (state_r == S_CIR)),
      .loadVal  (`BSI_IR_CAPTURE),
      .shiftEn  (tckRise & (state_r == S_SHI)),
      .serIn    (tdi),
      .updEn    (tckFall & updIrPend_r),
      .forceEn  (state_r == S_TLR),
      .forceVal (`BSI_OP_IDCODE),
      .shift_r  (irShift),
      .par_r    (irPar)
   );

   // Identification register
   bsi_shreg #(.W(`BSI_ID_W)) uId (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .loadEn   (tckRise & (state_r == S_CDR) & selId),
      .loadVal  (ID_VALUE),
      .shiftEn  (tckRise & (state_r == S_SHD) & selId),
      .serIn    (tdi),
      .updEn    (tckFall & updDrPend_r & selId),
      .forceEn  (1'b0),
      .forceVal (ID_VALUE),
      .shift_r  (idShift),
      .par_r    ()
   );

   // Capture: output cells sample system side, input cells sample pins
   assign bsrCapture[`BSI_NUM_IN-1:0]             = pinInSync;
   assign bsrCapture[`BSI_NUM_IN +: `BSI_NUM_OUT] = sysOut;
   assign bsrCapture[`BSI_BSR_W-1]                = sysOutEnN;

   // Boundary-scan register
   bsi_shreg #(.W(`BSI_BSR_W)) uBsr (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .loadEn   (tckRise & (state_r == S_CDR) & selBsr),
      .loadVal  (bsrCapture),
      .shiftEn  (tckRise & (state_r == S_SHD) & selBsr),
      .serIn    (tdi),
      .updEn    (tckFall & updDrPend_r & selBsr),
      .forceEn  (1'b0),
      .forceVal ({`BSI_BSR_W{1'b0}}),
      .shift_r  (bsrShift),
      .par_r    (bsrPar)
   );

   // Bypass stage: captures zero, shifts one bit
   always @(posedge clk_sys) begin
      if (rst) begin
         bypass_r <= 1'b0;
      end else if (tckRise & (state_r == S_CDR) & selBypass) begin
         bypass_r <= 1'b0;
      end else if (tckRise & (state_r == S_SHD) & selBypass) begin
         bypass_r <= tdi;
      end
   end

   // Serial output mux
   always @* begin
      if (state_r == S_SHI) begin
         shiftOut_nxt = irShift[0];
      end else if (selId) begin
         shiftOut_nxt = idShift[0];
      end else if (selBsr) begin
         shiftOut_nxt = bsrShift[0];
      end else begin
         shiftOut_nxt = bypass_r;
      end
   end

   // Serial output updates on falling edges, floats outside shift states
   always @(posedge clk_sys) begin
      if (rst) begin
         scanSerialOutO   <= 1'b0;
         scanSerialOutOeN <= 1'b1;
      end else if (tckFall) begin
         scanSerialOutO   <= shiftOut_nxt;
         scanSerialOutOeN <= ~((state_r == S_SHI) | (state_r == S_SHD));
      end
   end

   // Pin drivers: system function, boundary latches, or floating
   always @(posedge clk_sys) begin
      if (rst) begin
         pinOut    <= {`BSI_NUM_OUT{1'b0}};
         pinOutEnN <= 1'b1;
      end else if (pinMode(irPar) == 2'h2) begin
         pinOut    <= bsrPar[`BSI_NUM_IN +: `BSI_NUM_OUT];
         pinOutEnN <= 1'b1;
      end else if (pinMode(irPar) == 2'h1) begin
         pinOut    <= bsrPar[`BSI_NUM_IN +: `BSI_NUM_OUT];
         pinOutEnN <= bsrPar[`BSI_BSR_W-1];
      end else begin
         pinOut    <= sysOut;
         pinOutEnN <= sysOutEnN;
      end
   end

   // Status outputs
   always @(posedge clk_sys) begin
      if (rst) begin
         curInstr    <= `BSI_OP_IDCODE;
         tapStateIdx <= 4'h0;
      end else begin
         curInstr    <= irPar;
         tapStateIdx <= stIdx(state_r);
      end
   end
endmodule // bsi_scan_top

// ===== rtl/bsi_consts.vh
`ifndef BSI_CONSTS_VH
`define BSI_CONSTS_VH

// Instruction register width and instruction codes
`define BSI_IR_W          3
`define BSI_OP_EXTEST     3'h0
`define BSI_OP_IDCODE     3'h1
`define BSI_OP_SAMPLE     3'h2
`define BSI_OP_CLAMP      3'h3
`define BSI_OP_HIGHZ      3'h4
`define BSI_OP_BYPASS     3'h7
// Fixed pattern loaded in Capture-IR (low two bits 01)
`define BSI_IR_CAPTURE    3'h1

// Identification word layout
`define BSI_ID_W          32
`define BSI_ID_MARK_BIT   0
`define BSI_ID_MFR_LSB    1
`define BSI_ID_MFR_W      11
`define BSI_ID_DEV_LSB    12
`define BSI_ID_DEV_W      16
`define BSI_ID_VER_LSB    28
`define BSI_ID_VER_W      4

// Boundary-scan chain from bit 0: input cells, output cells, one control cell
`define BSI_NUM_IN        8
`define BSI_NUM_OUT       8
`define BSI_BSR_W         17

// Test access state count
`define BSI_TAP_STATES    16

`endif

// ===== rtl/bsi_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for signals from outside the clock domain
module bsi_sync #(
   parameter W = 1
) (
   input  wire         clk_sys,
   input  wire         rst,
   input  wire [W-1:0] asyncIn,
   output reg  [W-1:0] syncOut
);
   reg [W-1:0] meta_r;

   // First stage feeds only the second
   always @(posedge clk_sys) begin
      if (rst) begin
         meta_r  <= {W{1'b0}};
         syncOut <= {W{1'b0}};
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule // bsi_sync

// ===== rtl/bsi_shreg.v
`timescale 1ns/1ps
`include "bsi_consts.vh"
// Shift stage plus separately latched parallel output
module bsi_shreg #(
   parameter W = 3
) (
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         loadEn,
   input  wire [W-1:0] loadVal,
   input  wire         shiftEn,
   input  wire         serIn,
   input  wire         updEn,
   input  wire         forceEn,
   input  wire [W-1:0] forceVal,
   output reg  [W-1:0] shift_r,
   output reg  [W-1:0] par_r
);
   // Shift stage moves toward bit 0 (serial output end)
   always @(posedge clk_sys) begin
      if (rst) begin
         shift_r <= {W{1'b0}};
      end else if (loadEn) begin
         shift_r <= loadVal;
      end else if (shiftEn) begin
         shift_r <= {serIn, shift_r[W-1:1]};
      end
   end

   // Parallel latch, forced value has priority
   always @(posedge clk_sys) begin
      if (rst) begin
         par_r <= forceVal;
      end else if (forceEn) begin
         par_r <= forceVal;
      end else if (updEn) begin
         par_r <= shift_r;
      end
   end
endmodule // bsi_shreg

// ===== testbench/bsi_scan_assertions.sv
`timescale 1ns/1ps
`include "bsi_consts.vh"
// Port-level checks of the scan instruction logic
module bsi_scan_assertions (
   input wire                    clk_sys,
   input wire                    rst,
   input wire                    scan_clock,
   input wire                    scan_mode_select,
   input wire                    scan_serial_in,
   input wire                    scanSerialOutO,
   input wire                    scanSerialOutOeN,
   input wire [`BSI_NUM_IN-1:0]  sysPinIn,
   input wire [`BSI_NUM_OUT-1:0] sysOut,
   input wire                    sysOutEnN,
   input wire [`BSI_NUM_OUT-1:0] pinOut,
   input wire                    pinOutEnN,
   input wire [`BSI_IR_W-1:0]    curInstr,
   input wire [3:0]              tapStateIdx
);
   default clocking cb @(posedge clk_sys);
   endclocking
   // States reached only after a falling edge outside the shift states
   sequence s_restState;
      tapStateIdx inside {0, 1, 2, 3, 6, 7, 8, 9, 10, 13, 14, 15};
   endsequence
   // Falling test clock while shifting
   sequence s_shiftFall;
      $fell(scan_clock) && (tapStateIdx == 4'h4 || tapStateIdx == 4'hB);
   endsequence
   property p_resetState;
      rst |=> tapStateIdx == 4'h0 && curInstr == `BSI_OP_IDCODE && scanSerialOutOeN && pinOutEnN;
   endproperty
   property p_tlrForce;
      disable iff (rst) tapStateIdx == 4'h0 [*3] |-> curInstr == `BSI_OP_IDCODE;
   endproperty
   property p_oeRest;
      disable iff (rst) s_restState |-> scanSerialOutOeN;
   endproperty
   property p_oeShift;
      disable iff (rst) s_shiftFall |-> ##[2:6] !scanSerialOutOeN;
   endproperty
   property p_instrChange;
      disable iff (rst) $changed(curInstr) |-> tapStateIdx == 4'hF || tapStateIdx == 4'h0;
   endproperty
   property p_stateOnRise;
      disable iff (rst) $changed(tapStateIdx) |-> scan_clock;
   endproperty
   property p_highz;
      disable iff (rst) curInstr == `BSI_OP_HIGHZ [*2] |-> pinOutEnN;
   endproperty
   property p_passThrough;
      disable iff (rst) !$past(rst)
         && (curInstr == `BSI_OP_BYPASS || curInstr == `BSI_OP_IDCODE || curInstr == `BSI_OP_SAMPLE)
         |-> pinOut == $past(sysOut) && pinOutEnN == $past(sysOutEnN);
   endproperty
   property p_extestHold;
      disable iff (rst) (curInstr == `BSI_OP_EXTEST && !(tapStateIdx inside {4'h0, 4'h8, 4'hF})) [*3]
         |=> $stable(pinOut) && $stable(pinOutEnN);
   endproperty
   a_resetState: assert property (p_resetState) else $error("reset state wrong");
   a_tlrForce: assert property (p_tlrForce) else $error("reset state lost identification");
   a_oeRest: assert property (p_oeRest) else $error("serial out driven outside shift");
   a_oeShift: assert property (p_oeShift) else $error("serial out not driven in shift");
   a_instrChange: assert property (p_instrChange) else $error("instruction changed outside update");
   a_stateOnRise: assert property (p_stateOnRise) else $error("state moved without rising clock");
   a_highz: assert property (p_highz) else $error("outputs not floating");
   a_passThrough: assert property (p_passThrough) else $error("normal outputs disturbed");
   a_extestHold: assert property (p_extestHold) else $error("test outputs not held");
endmodule // bsi_scan_assertions

bind bsi_scan_top bsi_scan_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .scan_clock(scan_clock),
   .scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in), .scanSerialOutO(scanSerialOutO),
   .scanSerialOutOeN(scanSerialOutOeN), .sysPinIn(sysPinIn), .sysOut(sysOut), .sysOutEnN(sysOutEnN),
   .pinOut(pinOut), .pinOutEnN(pinOutEnN), .curInstr(curInstr), .tapStateIdx(tapStateIdx));

// ===== testbench/bsi_tap_model.sv
`timescale 1ns/1ps
// Test controller; its clock idles low between bits
module bsi_tap_model (
   output reg  scan_clock,
   output reg  scan_mode_select,
   output reg  scan_serial_in,
   input  wire scanSerialOutO,
   input  wire scanSerialOutOeN
);
   // Pin level, floating when not driven
   wire outLvl = scanSerialOutOeN ? 1'bz : scanSerialOutO;
   initial begin
      scan_clock = 1'b0;
      scan_mode_select = 1'b1;
      scan_serial_in = 1'b0;
   end
   // One period: set pins, sample output, rise, fall
   task tick(input m, input d, output q);
      begin
         scan_mode_select = m;
         scan_serial_in = d;
         #62.5;
         q = outLvl;
         scan_clock = 1'b1;
         #62.5;
         scan_clock = 1'b0;
      end
   endtask
   // Five high mode bits reach reset state, then idle
   task goIdle;
      reg q;
      begin
         repeat (5) tick(1'b1, 1'b0, q);
         tick(1'b0, 1'b0, q);
      end
   endtask
   // Scan n bits LSB first from idle, optional pause, back to idle
   task scan(input ir, input pause, input integer n, input [31:0] din, output [31:0] dout);
      integer i;
      reg q;
      begin
         dout = 32'h0;
         tick(1'b1, 1'b0, q);
         if (ir) tick(1'b1, 1'b0, q);
         tick(1'b0, 1'b0, q);
         tick(1'b0, 1'b0, q);
         for (i = 0; i < n; i = i + 1) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
         end
         if (pause) begin
            tick(1'b0, 1'b0, q);
            tick(1'b1, 1'b0, q);
         end
         tick(1'b1, 1'b0, q);
         tick(1'b0, 1'b0, q);
      end
   endtask
endmodule // bsi_tap_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
`include "bsi_consts.vh"
module tb;
   typedef struct packed {
      logic [2:0] op;
      logic [5:0] len;
      logic [1:0] pm;
   } bsi_row_t;
   // Identification fields, values arbitrary
   localparam [10:0] MFR = 11'h155;
   localparam [15:0] DEV = 16'h5A5A;
   localparam [3:0]  VER = 4'h3;
   localparam [31:0] ID_WORD = {VER, DEV, MFR, 1'b1};
   reg         clk_sys = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  sysPinIn = 8'h00;
   reg  [7:0]  sysOut = 8'h00;
   reg         sysOutEnN = 1'b1;
   wire        scan_clock, scan_mode_select, scan_serial_in, scanSerialOutO, scanSerialOutOeN, pinOutEnN;
   wire [7:0]  pinOut;
   wire [2:0]  curInstr;
   wire [3:0]  tapStateIdx;
   integer     num_errors = 0;
   integer     tests_run = 0;
   integer     i;
   reg  [31:0] dout, pat, expW;
   reg  [16:0] latchExp;
   bsi_row_t   rows [0:6];

   always #5 clk_sys = ~clk_sys;

   bsi_scan_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .VER_CODE(VER)) DUT (.clk_sys(clk_sys), .rst(rst),
      .scan_clock(scan_clock), .scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in),
      .scanSerialOutO(scanSerialOutO), .scanSerialOutOeN(scanSerialOutOeN), .sysPinIn(sysPinIn),
      .sysOut(sysOut), .sysOutEnN(sysOutEnN), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
      .curInstr(curInstr), .tapStateIdx(tapStateIdx));
   bsi_tap_model ctl (.scan_clock(scan_clock), .scan_mode_select(scan_mode_select),
      .scan_serial_in(scan_serial_in), .scanSerialOutO(scanSerialOutO), .scanSerialOutOeN(scanSerialOutOeN));

   // Compare one value
   task chkVal(input string name, input logic [31:0] exp, input logic [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", name, exp, got);
         end
      end
   endtask

   task report_and_stop;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // Watchdog
   initial begin
      #200000;
      num_errors = num_errors + 1;
      report_and_stop;
   end

   // Rows: instruction, data length seen, pin mode (0 system, 1 latches, 2 float)
   initial begin
      rows[0] = '{`BSI_OP_EXTEST, 6'd17, 2'd1};
      rows[1] = '{`BSI_OP_SAMPLE, 6'd17, 2'd0};
      rows[2] = '{`BSI_OP_CLAMP, 6'd1, 2'd1};
      rows[3] = '{`BSI_OP_HIGHZ, 6'd1, 2'd2};
      rows[4] = '{`BSI_OP_BYPASS, 6'd1, 2'd0};
      rows[5] = '{3'h5, 6'd1, 2'd0};
      rows[6] = '{`BSI_OP_IDCODE, 6'd32, 2'd0};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #2;
      ctl.goIdle;
      for (i = 0; i < 7; i = i + 1) begin
         pat = 32'h5A3C96E1 + i * 32'h11111111;
         @(posedge clk_sys);
         sysPinIn <= 8'hA5 ^ i[7:0];
         sysOut <= 8'h3C + i[7:0];
         sysOutEnN <= i[0];
         #2;
         ctl.scan(1'b1, i == 5, 3, {29'h0, rows[i].op}, dout);
         chkVal("ir capture", 32'h1, dout);
         chkVal("instruction", rows[i].op, curInstr);
         ctl.scan(1'b0, 1'b0, 32, pat, dout);
         if (rows[i].len == 6'd32)
            expW = ID_WORD;
         else if (rows[i].len == 6'd1)
            expW = {pat[30:0], 1'b0};
         else begin
            expW = {pat[14:0], sysOutEnN, sysOut, sysPinIn};
            latchExp = pat[31:15];
         end
         chkVal("data out", expW, dout);
         repeat (2) @(posedge clk_sys);
         #1;
         if (rows[i].pm == 2'd1)
            chkVal("pins", {latchExp[16], latchExp[15:8]}, {pinOutEnN, pinOut});
         else if (rows[i].pm == 2'd2)
            chkVal("pin enable", 32'h1, pinOutEnN);
         else
            chkVal("pins", {sysOutEnN, sysOut}, {pinOutEnN, pinOut});
      end
      // Reset state brings back identification
      ctl.scan(1'b1, 1'b0, 3, {29'h0, `BSI_OP_BYPASS}, dout);
      ctl.goIdle;
      chkVal("reset instruction", `BSI_OP_IDCODE, curInstr);
      ctl.scan(1'b0, 1'b0, 32, pat, dout);
      chkVal("default id", ID_WORD, dout);
      // Reset in mid-run under external test
      ctl.scan(1'b1, 1'b0, 3, {29'h0, `BSI_OP_EXTEST}, dout);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chkVal("reset state", {1'b1, 4'h0, `BSI_OP_IDCODE}, {pinOutEnN, tapStateIdx, curInstr});
      @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #2;
      ctl.goIdle;
      ctl.scan(1'b0, 1'b0, 32, pat, dout);
      chkVal("id after reset", ID_WORD, dout);
      report_and_stop;
   end
endmodule // tb
